/* verilog/cgs_clock_gen.sv */
// Clock generation unit: strap modes, PLL model, oscillator watchdog, APB
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cgs_cfg.svh"
// Summary of operation
// - Strap 001: CPU clock is input halved
// - Strap 011: CPU clock follows input directly
// - Strap 010: PLL with factor 1.5
// - Strap 100: PLL with factor 6.0
// - Strap 101: PLL, both dividers, factor 1.125
// - Strap 110: PLL with factor 3.0
// - Strap 111: default, PLL factor 4.5
// - Strap 000: PLL, both dividers, factor 0.375
// - Non-PLL modes: PLL free, disable bit stops it
// - PLL gives basic clock one ms after start
// - PLL locks one ms after stable input
// - PLL modes, missing input: unlock interrupt, basic frequency
// - Prescaler phase equals one input period
// - Watchdog: missing input, interrupt, PLL clock
// - Watchdog enable resets zero, then oscillator only
// - Back to oscillator only after reset
module cgs_clock_gen #(
	parameter int unsigned STARTUP_CYC = `CGS_STARTUP_CYC,
	parameter int unsigned LOCK_CYC = `CGS_LOCK_CYC
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [2:0] CLOCK_MODE_STRAPS,
	input wire logic CRYSTAL_INPUT,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic CPU_CLK,
	output logic PLL_LOCKED,
	output logic IRQ
);
	import cgs_pkg::*;
	localparam logic [3:0] BASIC_LAST = 4'(`CGS_BASIC_HALF_CYC - 1);

	cgs_xmon_t mon;
	cgs_mode_t mode_r;
	cgs_pll_st_t pll_r;
	cgs_pll_st_t pll_nxt;
	logic [2:0] strap_r;
	logic taken_r;
	logic [5:0] f8_r;
	logic osc_wdog_en_r;
	logic pll_disable_r;
	logic [1:0] stat_r;
	logic [1:0] stat_nxt;
	logic [1:0] mask_r;
	logic [1:0] mask_nxt;
	logic wdog_switched_r;
	logic cpu_clk_r;
	logic pll_locked_r;
	logic irq_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [3:0] basic_cnt_r;
	logic basic_tick;
	logic [15:0] acc_r;
	logic [15:0] acc_sum;
	logic [15:0] acc_thr;
	logic nco_tick;
	logic pll_off;
	logic pll_runs;
	logic present;
	logic start_done;
	logic lock_done;
	logic unlock_ev;
	logic wdog_ev;
	logic use_pll;
	logic apb_acc;
	logic apb_take;
	logic wr;
	logic rd_hit;
	logic [31:0] rd_data;

	function automatic cgs_mode_t strap_mode(input logic [2:0] s);
		if (s == `CGS_STRAP_PRESC) begin
			return CGS_PRESC;
		end else if (s == `CGS_STRAP_DIRECT) begin
			return CGS_DIRECT;
		end else begin
			return CGS_PLL;
		end
	endfunction

	function automatic logic [5:0] strap_f8(input logic [2:0] s);
		logic [5:0] f;
		f = 6'h00;
		case (s)
			`CGS_STRAP_F1P5: f = `CGS_F8_1P5;
			`CGS_STRAP_F6P0: f = `CGS_F8_6P0;
			`CGS_STRAP_F1P125: f = `CGS_F8_1P125;
			`CGS_STRAP_F3P0: f = `CGS_F8_3P0;
			`CGS_STRAP_F4P5: f = `CGS_F8_4P5;
			`CGS_STRAP_F0P375: f = `CGS_F8_0P375;
			default: f = 6'h00;
		endcase
		return f;
	endfunction

	cgs_xmon u_xmon (
		.clk(CLK),
		.rst_n(RST_N),
		.crystal(CRYSTAL_INPUT),
		.mon(mon)
	);

	cgs_timer #(.LIMIT(STARTUP_CYC), .W(20)) u_start (
		.clk(CLK),
		.rst_n(RST_N),
		.clear(pll_r != CGS_ST_START),
		.run(pll_r == CGS_ST_START),
		.done(start_done)
	);

	cgs_timer #(.LIMIT(LOCK_CYC), .W(20)) u_lock (
		.clk(CLK),
		.rst_n(RST_N),
		.clear(pll_r != CGS_ST_LOCKING),
		.run(pll_r == CGS_ST_LOCKING),
		.done(lock_done)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			taken_r <= 1'b0;
			strap_r <= `CGS_STRAP_F4P5;
			mode_r <= CGS_PLL;
			f8_r <= `CGS_F8_4P5;
		end else if (!taken_r) begin
			taken_r <= 1'b1;
			strap_r <= CLOCK_MODE_STRAPS;
			mode_r <= strap_mode(CLOCK_MODE_STRAPS);
			f8_r <= strap_f8(CLOCK_MODE_STRAPS);
		end
	end

	// disable bit only acts outside PLL modes
	assign pll_off = taken_r && (mode_r != CGS_PLL) && pll_disable_r;
	assign pll_runs = (pll_r != CGS_ST_OFF) && (pll_r != CGS_ST_START);
	assign present = !mon.missing && (mon.period != 12'h000);

	always_comb begin
		pll_nxt = pll_r;
		case (pll_r)
			CGS_ST_OFF: begin
				pll_nxt = CGS_ST_START;
			end
			CGS_ST_START: begin
				if (start_done) begin
					pll_nxt = CGS_ST_BASIC;
				end
			end
			CGS_ST_BASIC: begin
				if (present) begin
					pll_nxt = CGS_ST_LOCKING;
				end
			end
			CGS_ST_LOCKING: begin
				if (mon.missing) begin
					pll_nxt = CGS_ST_BASIC;
				end else if (lock_done) begin
					pll_nxt = CGS_ST_LOCKED;
				end
			end
			CGS_ST_LOCKED: begin
				if (mon.missing) begin
					pll_nxt = CGS_ST_BASIC;
				end
			end
			default: begin
				pll_nxt = CGS_ST_START;
			end
		endcase
		if (pll_off) begin
			pll_nxt = CGS_ST_OFF;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pll_r <= CGS_ST_START;
			pll_locked_r <= 1'b0;
		end else begin
			pll_r <= pll_nxt;
			pll_locked_r <= (pll_nxt == CGS_ST_LOCKED);
		end
	end

	assign unlock_ev = (mode_r == CGS_PLL) && (pll_r == CGS_ST_LOCKED) &&
		mon.missing;
	assign wdog_ev = taken_r && (mode_r != CGS_PLL) && osc_wdog_en_r &&
		pll_runs && mon.missing && !wdog_switched_r;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wdog_switched_r <= 1'b0;
		end else if (wdog_ev) begin
			wdog_switched_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			basic_cnt_r <= '0;
		end else if (basic_tick || !pll_runs) begin
			basic_cnt_r <= '0;
		end else begin
			basic_cnt_r <= basic_cnt_r + 1'b1;
		end
	end
	assign basic_tick = pll_runs && (basic_cnt_r == BASIC_LAST);

	// Phase accumulator: toggles at twice F times the input rate
	assign acc_thr = {2'b00, mon.period, 2'b00};
	assign acc_sum = acc_r + {10'h000, f8_r};
	assign nco_tick = (pll_r == CGS_ST_LOCKED) && (acc_sum >= acc_thr);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			acc_r <= '0;
		end else if (pll_r != CGS_ST_LOCKED) begin
			acc_r <= '0;
		end else if (nco_tick) begin
			acc_r <= acc_sum - acc_thr;
		end else begin
			acc_r <= acc_sum;
		end
	end

	assign use_pll = (mode_r == CGS_PLL) || wdog_switched_r;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cpu_clk_r <= 1'b0;
		end else if (!taken_r) begin
			cpu_clk_r <= 1'b0;
		end else if (use_pll) begin
			if ((mode_r == CGS_PLL) && (pll_r == CGS_ST_LOCKED)) begin
				cpu_clk_r <= cpu_clk_r ^ nco_tick;
			end else begin
				cpu_clk_r <= cpu_clk_r ^ basic_tick;
			end
		end else if (mode_r == CGS_PRESC) begin
			cpu_clk_r <= cpu_clk_r ^ mon.rise;
		end else begin
			cpu_clk_r <= CRYSTAL_INPUT;
		end
	end

	// APB slave, one wait state
	assign apb_acc = PSEL && PENABLE;
	assign apb_take = apb_acc && pready_r;
	assign wr = apb_take && PWRITE && rd_hit;

	always_comb begin
		rd_hit = 1'b1;
		rd_data = 32'h0000_0000;
		if (PADDR == `CGS_OFS_SYSCFG_MAIN) begin
			rd_data[`CGS_BIT_OSC_WDOG_EN] = osc_wdog_en_r;
		end else if (PADDR == `CGS_OFS_SYSCFG_THREE) begin
			rd_data[`CGS_BIT_PLL_DISABLE] = pll_disable_r;
		end else if (PADDR == `CGS_OFS_IRQ_STATUS) begin
			rd_data[1:0] = stat_r;
		end else if (PADDR == `CGS_OFS_IRQ_MASK) begin
			rd_data[1:0] = mask_r;
		end else if (PADDR == `CGS_OFS_CLK_STATUS) begin
			rd_data[7:0] = {pll_runs, wdog_switched_r, pll_locked_r, strap_r,
				mode_r};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= apb_acc && !pready_r;
			pslverr_r <= apb_acc && !pready_r && !rd_hit;
			if (apb_acc && !pready_r && !PWRITE) begin
				prdata_r <= rd_data;
			end else if (apb_take) begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			osc_wdog_en_r <= `CGS_RST_OSC_WDOG_EN;
			pll_disable_r <= `CGS_RST_PLL_DISABLE;
			mask_r <= `CGS_RST_IRQ_MASK;
		end else if (wr) begin
			if ((PADDR == `CGS_OFS_SYSCFG_MAIN) && PSTRB[0]) begin
				osc_wdog_en_r <= PWDATA[`CGS_BIT_OSC_WDOG_EN];
			end else if ((PADDR == `CGS_OFS_SYSCFG_THREE) && PSTRB[1]) begin
				pll_disable_r <= PWDATA[`CGS_BIT_PLL_DISABLE];
			end else if ((PADDR == `CGS_OFS_IRQ_MASK) && PSTRB[0]) begin
				mask_r <= PWDATA[1:0];
			end
		end
	end

	// Write one clears, a new event wins
	always_comb begin
		stat_nxt = stat_r;
		// Interrupt level follows a mask write in the same edge
		mask_nxt = mask_r;
		if (wr && (PADDR == `CGS_OFS_IRQ_MASK) && PSTRB[0]) begin
			mask_nxt = PWDATA[1:0];
		end
		if (wr && (PADDR == `CGS_OFS_IRQ_STATUS) && PSTRB[0]) begin
			stat_nxt = stat_r & ~PWDATA[1:0];
		end
		stat_nxt[`CGS_IRQ_UNLOCK] = stat_nxt[`CGS_IRQ_UNLOCK] | unlock_ev;
		stat_nxt[`CGS_IRQ_WDOG] = stat_nxt[`CGS_IRQ_WDOG] | wdog_ev;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			stat_r <= 2'h0;
			irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq_r <= |(stat_nxt & mask_nxt);
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign CPU_CLK = cpu_clk_r;
	assign PLL_LOCKED = pll_locked_r;
	assign IRQ = irq_r;

	a_strap_hold: assert property (
		@(posedge CLK) disable iff (!RST_N)
		taken_r |=> (taken_r && $stable(mode_r) && $stable(f8_r))
	) else $error("Clock mode changed after strap latch");

	a_presc_half: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(taken_r && mode_r == CGS_PRESC && !wdog_switched_r && !wdog_ev)
		|-> ##1 (cpu_clk_r != $past(cpu_clk_r)) == $past(mon.rise)
	) else $error("Prescaler clock did not follow input edges");

	a_direct_follow: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(taken_r && mode_r == CGS_DIRECT && !wdog_switched_r && !wdog_ev)
		|=> cpu_clk_r == $past(CRYSTAL_INPUT)
	) else $error("Direct drive clock does not follow input");

	a_wdog_sticky: assert property (
		@(posedge CLK) disable iff (!RST_N)
		wdog_switched_r |=> wdog_switched_r
	) else $error("Watchdog switch released without reset");

	a_wdog_enable: assert property (
		@(posedge CLK) disable iff (!RST_N)
		$rose(wdog_switched_r) |-> ($past(osc_wdog_en_r) &&
			stat_r[`CGS_IRQ_WDOG])
	) else $error("Watchdog acted while disabled or without flag");

	a_unlock_flag: assert property (
		@(posedge CLK) disable iff (!RST_N)
		unlock_ev |=> (stat_r[`CGS_IRQ_UNLOCK] && pll_r == CGS_ST_BASIC)
	) else $error("Unlock did not flag or fall back to basic");

	a_start_wait: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(pll_r == CGS_ST_START && !start_done) |=>
			(pll_r == CGS_ST_START || pll_r == CGS_ST_OFF)
	) else $error("PLL left start-up before the delay");

	a_lock_wait: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(pll_r == CGS_ST_LOCKING && !lock_done && !mon.missing && !pll_off)
		|=> pll_r == CGS_ST_LOCKING
	) else $error("PLL locked before the lock delay");

	a_pll_disable: assert property (
		@(posedge CLK) disable iff (!RST_N)
		pll_off |=> (pll_r == CGS_ST_OFF && !pll_locked_r)
	) else $error("PLL still running while disabled");

	a_irq_level: assert property (
		@(posedge CLK) disable iff (!RST_N)
		##1 irq_r == |(stat_r & mask_r)
	) else $error("Interrupt output disagrees with status and mask");
endmodule
`default_nettype wire

/* shared/cgs_cfg.svh */
// Register map, field positions, reset values and timing counts
`ifndef CGS_CFG_SVH
`define CGS_CFG_SVH

`define CGS_OFS_SYSCFG_MAIN 12'h000
`define CGS_OFS_SYSCFG_THREE 12'h004
`define CGS_OFS_IRQ_STATUS 12'h008
`define CGS_OFS_IRQ_MASK 12'h00C
`define CGS_OFS_CLK_STATUS 12'h010

`define CGS_BIT_OSC_WDOG_EN 0
`define CGS_BIT_PLL_DISABLE 13
`define CGS_IRQ_UNLOCK 0
`define CGS_IRQ_WDOG 1

`define CGS_RST_OSC_WDOG_EN 1'b0
`define CGS_RST_PLL_DISABLE 1'b0
`define CGS_RST_IRQ_MASK 2'h0

`define CGS_STRAP_PRESC 3'h1
`define CGS_STRAP_DIRECT 3'h3
`define CGS_STRAP_F1P5 3'h2
`define CGS_STRAP_F6P0 3'h4
`define CGS_STRAP_F1P125 3'h5
`define CGS_STRAP_F3P0 3'h6
`define CGS_STRAP_F4P5 3'h7
`define CGS_STRAP_F0P375 3'h0

// Multiplication factors in eighths
`define CGS_F8_1P5 6'h0C
`define CGS_F8_6P0 6'h30
`define CGS_F8_1P125 6'h09
`define CGS_F8_3P0 6'h18
`define CGS_F8_4P5 6'h24
`define CGS_F8_0P375 6'h03

`define CGS_CLK_NS 20
`define CGS_NS_PER_MS 1000000
`define CGS_STARTUP_MS 1
`define CGS_LOCK_MS 1
`define CGS_STARTUP_CYC (`CGS_STARTUP_MS * `CGS_NS_PER_MS / `CGS_CLK_NS)
`define CGS_LOCK_CYC (`CGS_LOCK_MS * `CGS_NS_PER_MS / `CGS_CLK_NS)
`define CGS_MISS_NS 500
`define CGS_MISS_CYC ((`CGS_MISS_NS + `CGS_CLK_NS - 1) / `CGS_CLK_NS)
`define CGS_BASIC_HALF_NS 140
`define CGS_BASIC_HALF_CYC (`CGS_BASIC_HALF_NS / `CGS_CLK_NS)

`endif

/* shared/cgs_pkg.sv */
// Types shared by the clock generation block
package cgs_pkg;
	typedef enum logic [1:0] {CGS_PRESC, CGS_DIRECT, CGS_PLL} cgs_mode_t;
	typedef enum logic [2:0] {
		CGS_ST_OFF, CGS_ST_START, CGS_ST_BASIC, CGS_ST_LOCKING, CGS_ST_LOCKED
	} cgs_pll_st_t;
	typedef struct packed {
		logic rise;
		logic missing;
		logic [11:0] period;
	} cgs_xmon_t;
endpackage

/* verilog/cgs_timer.sv */
// Run-time counter that flags when a fixed number of cycles has elapsed
`timescale 1ns/1ps
`default_nettype none
module cgs_timer #(
	parameter int unsigned LIMIT = 16,
	parameter int unsigned W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic run,
	output logic done
);
	localparam logic [W-1:0] LAST = W'(LIMIT - 1);
	logic [W-1:0] cnt_r;
	logic done_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else if (clear) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else if (run && !done_r) begin
			if (cnt_r == LAST) begin
				done_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	assign done = done_r;
endmodule
`default_nettype wire

/* verilog/cgs_xmon.sv */
// Crystal input monitor: edge, period in clock cycles, missing transitions
`timescale 1ns/1ps
`default_nettype none
`include "cgs_cfg.svh"
module cgs_xmon (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic crystal,
	output cgs_pkg::cgs_xmon_t mon
);
	import cgs_pkg::*;
	localparam logic [11:0] MISS_LAST = 12'(`CGS_MISS_CYC - 1);
	logic crystal_d_r;
	logic [11:0] cnt_r;
	logic [11:0] period_r;
	logic missing_r;
	logic rise;

	assign rise = crystal && !crystal_d_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crystal_d_r <= 1'b0;
		end else begin
			crystal_d_r <= crystal;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			period_r <= '0;
		end else if (rise) begin
			cnt_r <= '0;
			period_r <= cnt_r + 1'b1;
		end else if (cnt_r != 12'hFFF) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Missing once no rising edge was seen for the timeout
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			missing_r <= 1'b0;
		end else begin
			missing_r <= !rise && (cnt_r >= MISS_LAST);
		end
	end

	assign mon = '{rise: rise, missing: missing_r, period: period_r};
endmodule
`default_nettype wire

/* tb/cgs_xtal_model.sv */
// Crystal oscillator source model that can be stopped and restarted
`timescale 1ns/1ps
`default_nettype none
module cgs_xtal_model (
	input wire logic clk,
	input wire logic run,
	input wire logic [3:0] half,
	output logic xtal
);
	logic [3:0] cnt_r;
	initial begin
		xtal = 1'b0;
		cnt_r = 4'h0;
	end
	// A failed crystal sits at its last level, with no transitions
	always @(posedge clk) begin
		if (run) begin
			if (cnt_r + 4'h1 >= half) begin
				cnt_r <= 4'h0;
				xtal <= ~xtal;
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the clock generation block
`timescale 1ns/1ps
`default_nettype none
`include "cgs_cfg.svh"
module tb;
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] straps = 3'h7;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic xtal_run = 1'b1;
	logic [3:0] xtal_half = 4'h8;
	logic [31:0] rng = 32'h0000_0062;
	logic [31:0] q;
	logic [31:0] t;
	logic err;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, cpu_clk, pll_locked, irq, xtal;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	cgs_clock_gen #(.STARTUP_CYC(20), .LOCK_CYC(30)) uut (.CLK(clk),
		.RST_N(rst_n), .CLOCK_MODE_STRAPS(straps), .CRYSTAL_INPUT(xtal),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CPU_CLK(cpu_clk), .PLL_LOCKED(pll_locked),
		.IRQ(irq));
	cgs_xtal_model xm (.clk(clk), .run(xtal_run), .half(xtal_half),
		.xtal(xtal));

	always #10 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [1:0] mode_of(input int s);
		return (s == 1) ? 2'h0 : (s == 3) ? 2'h1 : 2'h2;
	endfunction
	// Factor in eighths; toggles over eight input periods are twice this
	function automatic int f8_of(input int s);
		int f[8] = '{3, 0, 12, 0, 48, 9, 24, 36};
		return f[s];
	endfunction

	task automatic end_of_test();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] s,
		input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", pready, 1);
		@(posedge clk);
	endtask
	task automatic rd(input string w, input logic [11:0] a,
		input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(w, q & m, e);
	endtask
	task automatic toggles(input int n);
		logic last;
		last = cpu_clk;
		t = 0;
		repeat (n) begin
			@(posedge clk);
			if (cpu_clk !== last) t++;
			last = cpu_clk;
		end
	endtask
	task automatic do_reset(input logic [2:0] s);
		rst_n <= 1'b0;
		straps <= s;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		straps <= ~s;
		@(posedge clk);
	endtask
	task automatic wait_lock();
		int n;
		n = 0;
		while (pll_locked !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		for (int s = 0; s < 8; s++) begin
			rng = xs(rng);
			xtal_half <= (s == 1 || s == 3) ? 4'(2 + rng[3:0] % 7) : 4'h8;
			do_reset(s[2:0]);
			rd("mode", `CGS_OFS_CLK_STATUS, 32'h0000_001F,
				{27'h0, s[2:0], mode_of(s)});
			rd("main", `CGS_OFS_SYSCFG_MAIN, 32'h0000_0001, 0);
			rd("three", `CGS_OFS_SYSCFG_THREE, 32'h0000_2000, 0);
			rd("mask", `CGS_OFS_IRQ_MASK, 32'h0000_0003, 0);
			if (s == 1 || s == 3) begin
				toggles(16 * xtal_half);
				chk("ext rate", t, (s == 1) ? 8 : 16);
			end else begin
				// measure only once the loop has locked
				wait_lock();
				chk("locked", pll_locked, 1);
				toggles(128);
				chk("pll rate", t + 1 >= 2 * f8_of(s) &&
					t <= 2 * f8_of(s) + 1, 1);
			end
		end
		apb(1'b1, 12'h014, rng);
		chk("unmapped err", err, 1);
		// Loss of input while locked in the default PLL mode
		xtal_run <= 1'b0;
		repeat (40) @(posedge clk);
		chk("unlocked", pll_locked, 0);
		rd("unlock stat", `CGS_OFS_IRQ_STATUS, 32'h0000_0003, 1);
		chk("irq masked", irq, 0);
		apb(1'b1, `CGS_OFS_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("irq set", irq, 1);
		toggles(70);
		chk("basic rate", t, 10);
		apb(1'b1, `CGS_OFS_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("irq clear", irq, 0);
		rd("stat clear", `CGS_OFS_IRQ_STATUS, 32'h0000_0003, 0);
		xtal_run <= 1'b1;
		wait_lock();
		chk("relock", pll_locked, 1);
		// Direct drive: watchdog off, then on
		xtal_half <= 4'h4;
		do_reset(3'h3);
		repeat (40) @(posedge clk);
		xtal_run <= 1'b0;
		repeat (40) @(posedge clk);
		rd("wdog off", `CGS_OFS_IRQ_STATUS, 32'h0000_0003, 0);
		toggles(70);
		chk("osc only", t, 0);
		xtal_run <= 1'b1;
		// Let the input be seen again before the watchdog is armed
		repeat (20) @(posedge clk);
		apb(1'b1, `CGS_OFS_SYSCFG_MAIN, 32'h0000_0001);
		repeat (10) @(posedge clk);
		xtal_run <= 1'b0;
		repeat (40) @(posedge clk);
		rd("wdog stat", `CGS_OFS_IRQ_STATUS, 32'h0000_0003, 2);
		rd("switched", `CGS_OFS_CLK_STATUS, 32'h0000_0040, 32'h40);
		toggles(70);
		chk("wdog rate", t, 10);
		xtal_run <= 1'b1;
		repeat (20) @(posedge clk);
		toggles(70);
		chk("stay basic", t, 10);
		// Prescaler with the PLL switched off gives no watchdog
		do_reset(3'h1);
		apb(1'b1, `CGS_OFS_SYSCFG_THREE, 32'h0000_2000);
		repeat (10) @(posedge clk);
		rd("pll off", `CGS_OFS_CLK_STATUS, 32'h0000_0080, 0);
		apb(1'b1, `CGS_OFS_SYSCFG_MAIN, 32'h0000_0001);
		xtal_run <= 1'b0;
		repeat (40) @(posedge clk);
		rd("no wdog", `CGS_OFS_IRQ_STATUS, 32'h0000_0003, 0);
		xtal_run <= 1'b1;
		end_of_test();
	end
endmodule
`default_nettype wire
